//--- common/logic_shift_bit_alu_defines.svh
`ifndef LOGIC_SHIFT_BIT_ALU_DEFINES_SVH
`define LOGIC_SHIFT_BIT_ALU_DEFINES_SVH

// ****************************************************************
// Widths, masks and reset values
// ****************************************************************
`define ALU_DATA_W    32
`define ALU_NUM_LONG  8
`define ALU_BIT_IDX_W 3
`define ALU_REG_RST   32'h0000_0000
`define ALU_MASK_B    32'h0000_00ff
`define ALU_MASK_W    32'h0000_ffff
`define ALU_MASK_L    32'hffff_ffff
`define ALU_MSB_B     5'h07
`define ALU_MSB_W     5'h0f
`define ALU_MSB_L     5'h1f

`endif

//--- common/logic_shift_bit_alu_pkg.sv
package logic_shift_bit_alu_pkg;

	// ****************************************************************
	// Operation, size and carrier types
	// ****************************************************************
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} size_e;

	typedef enum logic [3:0] {
		OP_AND               = 4'h0,
		OP_OR                = 4'h1,
		OP_XOR               = 4'h2,
		OP_NOT               = 4'h3,
		OP_ARITH_SHIFT_LEFT  = 4'h4,
		OP_ARITH_SHIFT_RIGHT = 4'h5,
		OP_LOGIC_SHIFT_LEFT  = 4'h6,
		OP_LOGIC_SHIFT_RIGHT = 4'h7,
		OP_ROTATE_LEFT       = 4'h8,
		OP_ROTATE_RIGHT      = 4'h9,
		OP_ROTATE_CARRY_LEFT = 4'ha,
		OP_ROTATE_CARRY_RIGHT = 4'hb,
		OP_BIT_SET           = 4'hc,
		OP_BIT_CLEAR         = 4'hd
	} op_e;

	typedef struct packed {
		logic        valid;
		op_e         op;
		size_e       size;
		logic [3:0]  dst;
		logic [3:0]  source_register;
		logic        use_imm;
		logic [31:0] immediate_value;
		logic        mem_op;
		logic [7:0]  mem_data;
	} req_s;

	typedef struct packed {
		logic        valid;
		logic [2:0]  idx;
		logic [31:0] data;
	} load_s;

	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} flags_s;

endpackage : logic_shift_bit_alu_pkg

//--- rtl/logic_shift_bit_alu.sv
`timescale 1ns/1ps
`include "logic_shift_bit_alu_defines.svh"

// Overview of operation
// - AND destination with register or immediate
// - OR destination with register or immediate
// - XOR destination with register or immediate
// - NOT inverts every bit of the sized destination view in place
// - Arithmetic shifts left and right, written back
// - Logical shifts fill with zero, written back
// - Rotates wrap the outgoing bit around
// - Rotates through carry include carry bit
// - Bit set forces indexed byte bit
// - Bit clear zeroes indexed byte bit
// - Registers viewed as bytes, words, longwords
module logic_shift_bit_alu (
	input  wire logic                           clk_i,       // CPU clock
	input  wire logic                           rstn_i,      // Synchronous reset, low
	input  wire logic_shift_bit_alu_pkg::req_s  req_i,       // Operation request
	input  wire logic_shift_bit_alu_pkg::load_s load_i,      // Longword register load
	input  wire logic [2:0]                     peek_idx_i,  // Longword register to read
	output logic                                done_o,      // Operation completed
	output logic [31:0]                         result_o,    // Operation result
	output logic_shift_bit_alu_pkg::flags_s     flags_o,     // Condition flags
	output logic                                mem_wr_o,    // Memory byte write strobe
	output logic [7:0]                          mem_data_o,  // Memory byte write data
	output logic [31:0]                         peek_data_o  // Register read data
);
	import logic_shift_bit_alu_pkg::*;

	logic [31:0] regs      [`ALU_NUM_LONG];
	logic [31:0] next_regs [`ALU_NUM_LONG];
	flags_s      flags;
	flags_s      next_flags;
	logic        next_done;
	logic [31:0] next_result;
	logic        next_mem_wr;
	logic [7:0]  next_mem_data;
	logic [31:0] next_peek;

	logic [31:0] dst_long;
	logic [31:0] src_long;
	logic [31:0] opa;
	logic [31:0] opb;
	logic [31:0] mask;
	logic [31:0] smask;
	logic [4:0]  msb;
	logic [7:0]  bit_byte;
	logic [7:0]  bit_mask;
	logic [2:0]  bit_idx;
	logic [31:0] res;
	logic        is_bit;
	logic [31:0] dst_view_b;
	logic [31:0] src_view_b;

	// ****************************************************************
	// Sub-register views
	// ****************************************************************
	// Selector bit 3 picks the low byte of a word or the upper word of a longword.
	function automatic logic [31:0] pick(input logic [31:0] l, input logic [3:0] sel,
		input size_e sz);
		unique case (sz)
			SZ_BYTE: pick = sel[3] ? {24'h000000, l[7:0]} : {24'h000000, l[15:8]};
			SZ_WORD: pick = sel[3] ? {16'h0000, l[31:16]} : {16'h0000, l[15:0]};
			default: pick = l;
		endcase
	endfunction : pick

	function automatic logic [31:0] merge(input logic [31:0] l, input logic [31:0] v,
		input logic [3:0] sel, input size_e sz);
		unique case (sz)
			SZ_BYTE: merge = sel[3] ? {l[31:8], v[7:0]} : {l[31:16], v[7:0], l[7:0]};
			SZ_WORD: merge = sel[3] ? {v[15:0], l[15:0]} : {l[31:16], v[15:0]};
			default: merge = v;
		endcase
	endfunction : merge

	assign dst_long = regs[req_i.dst[2:0]];
	assign src_long = regs[req_i.source_register[2:0]];
	assign opa      = pick(dst_long, req_i.dst, req_i.size);
	assign opb      = req_i.use_imm ? (req_i.immediate_value & mask) :
		pick(src_long, req_i.source_register, req_i.size);
	assign is_bit   = (req_i.op == OP_BIT_SET) || (req_i.op == OP_BIT_CLEAR);
	assign dst_view_b = pick(dst_long, req_i.dst, SZ_BYTE);
	assign src_view_b = pick(src_long, req_i.source_register, SZ_BYTE);
	// Bit ops always work on a byte view, whatever the size field says.
	assign bit_byte = req_i.mem_op ? req_i.mem_data : dst_view_b[7:0];
	assign bit_idx  = req_i.use_imm ? req_i.immediate_value[2:0] : src_view_b[2:0];
	assign bit_mask = 8'h01 << bit_idx;
	assign smask    = mask ^ (mask >> 1);

	always_comb begin
		unique case (req_i.size)
			SZ_BYTE: begin
				mask = `ALU_MASK_B;
				msb  = `ALU_MSB_B;
			end
			SZ_WORD: begin
				mask = `ALU_MASK_W;
				msb  = `ALU_MSB_W;
			end
			default: begin
				mask = `ALU_MASK_L;
				msb  = `ALU_MSB_L;
			end
		endcase
	end

	// ****************************************************************
	// Operation datapath
	// ****************************************************************
	always_comb begin
		next_regs     = regs;
		next_flags    = flags;
		next_done     = 1'b0;
		next_result   = result_o;
		next_mem_wr   = 1'b0;
		next_mem_data = mem_data_o;
		next_peek     = regs[peek_idx_i];
		res           = opa;
		if (req_i.valid) begin
			next_flags.v = 1'b0;
			unique case (req_i.op)
				OP_AND: res = opa & opb;
				OP_OR: res = opa | opb;
				OP_XOR: res = opa ^ opb;
				OP_NOT: res = ~opa & mask;
				OP_ARITH_SHIFT_LEFT: begin
					res          = (opa << 1) & mask;
					next_flags.c = opa[msb];
					next_flags.v = opa[msb] ^ res[msb];
				end
				OP_ARITH_SHIFT_RIGHT: begin
					res          = (opa >> 1) | (opa & smask);
					next_flags.c = opa[0];
				end
				OP_LOGIC_SHIFT_LEFT: begin
					res          = (opa << 1) & mask;
					next_flags.c = opa[msb];
				end
				OP_LOGIC_SHIFT_RIGHT: begin
					res          = opa >> 1;
					next_flags.c = opa[0];
				end
				OP_ROTATE_LEFT: begin
					res          = ((opa << 1) & mask) | {31'h0, opa[msb]};
					next_flags.c = opa[msb];
				end
				OP_ROTATE_RIGHT: begin
					res          = (opa >> 1) | (opa[0] ? smask : 32'h0);
					next_flags.c = opa[0];
				end
				OP_ROTATE_CARRY_LEFT: begin
					res          = ((opa << 1) & mask) | {31'h0, flags.c};
					next_flags.c = opa[msb];
				end
				OP_ROTATE_CARRY_RIGHT: begin
					res          = (opa >> 1) | (flags.c ? smask : 32'h0);
					next_flags.c = opa[0];
				end
				OP_BIT_SET: res = {24'h0, bit_byte | bit_mask};
				OP_BIT_CLEAR: res = {24'h0, bit_byte & ~bit_mask};
				default: res = opa;
			endcase
			next_done   = 1'b1;
			next_result = res;
			if (is_bit) begin
				next_flags = flags;
			end else begin
				next_flags.n = res[msb];
				next_flags.z = (res == 32'h0);
			end
			if (is_bit && req_i.mem_op) begin
				next_mem_wr   = 1'b1;
				next_mem_data = res[7:0];
			end else begin
				next_regs[req_i.dst[2:0]] = merge(dst_long, res, req_i.dst,
					is_bit ? SZ_BYTE : req_i.size);
			end
		end
		if (load_i.valid) begin
			next_regs[load_i.idx] = load_i.data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < `ALU_NUM_LONG; i++) begin
				regs[i] <= `ALU_REG_RST;
			end
			flags       <= '0;
			done_o      <= 1'b0;
			result_o    <= 32'h0;
			mem_wr_o    <= 1'b0;
			mem_data_o  <= 8'h00;
			peek_data_o <= 32'h0;
		end else begin
			regs        <= next_regs;
			flags       <= next_flags;
			done_o      <= next_done;
			result_o    <= next_result;
			mem_wr_o    <= next_mem_wr;
			mem_data_o  <= next_mem_data;
			peek_data_o <= next_peek;
		end
	end

	assign flags_o = flags;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_and_long: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.op == OP_AND && req_i.size == SZ_LONG
		|=> result_o == ($past(dst_long) & $past(opb)) && done_o)
		else $error("AND result wrong");
	a_or_word: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.op == OP_OR && req_i.size == SZ_WORD
		|=> result_o == {16'h0, $past(opa[15:0]) | $past(opb[15:0])})
		else $error("OR result wrong");
	a_xor_byte: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.op == OP_XOR && req_i.size == SZ_BYTE
		|=> result_o == {24'h0, $past(opa[7:0]) ^ $past(opb[7:0])})
		else $error("XOR result wrong");
	a_not_long: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.op == OP_NOT && req_i.size == SZ_LONG && !load_i.valid
		|=> regs[$past(req_i.dst[2:0])] == ~$past(dst_long))
		else $error("NOT write-back wrong");
	a_arith_sign: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.op == OP_ARITH_SHIFT_RIGHT && req_i.size == SZ_BYTE
		|=> result_o[7:6] == {2{$past(opa[7])}} && flags_o.c == $past(opa[0]))
		else $error("arith right shift lost sign");
	a_shift_left_fill: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.op == OP_LOGIC_SHIFT_LEFT && req_i.size == SZ_LONG
		|=> result_o == {$past(opa[30:0]), 1'b0} && flags_o.c == $past(opa[31]))
		else $error("logic left shift wrong");
	a_rotate_wrap: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.op == OP_ROTATE_LEFT && req_i.size == SZ_WORD
		|=> result_o[15:0] == {$past(opa[14:0]), $past(opa[15])})
		else $error("rotate left did not wrap");
	a_carry_rotate: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.op == OP_ROTATE_CARRY_RIGHT && req_i.size == SZ_BYTE
		|=> result_o[7:0] == {$past(flags.c), $past(opa[7:1])} && flags_o.c == $past(opa[0]))
		else $error("rotate through carry wrong");
	a_set_mem: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.op == OP_BIT_SET && req_i.mem_op
		|=> mem_wr_o && mem_data_o == ($past(req_i.mem_data) | $past(bit_mask))
			&& flags_o == $past(flags))
		else $error("bit set to memory wrong");
	a_clear_reg: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.op == OP_BIT_CLEAR && !req_i.mem_op
		|=> !mem_wr_o && result_o[7:0] == ($past(dst_view_b[7:0]) & ~$past(bit_mask)))
		else $error("bit clear wrong");
	a_byte_merge: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && req_i.size == SZ_BYTE && !req_i.mem_op && !load_i.valid
		&& req_i.dst[3] |=> regs[$past(req_i.dst[2:0])][31:8] == $past(dst_long[31:8]))
		else $error("byte write disturbed upper bits");
	a_zero_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.valid && !is_bit
		|=> flags_o.z == (result_o == 32'h0) && flags_o.n == $past(res[msb]))
		else $error("N or Z flag wrong");

endmodule : logic_shift_bit_alu

//--- test/tb.sv
`timescale 1ns/1ps

module tb;
	import logic_shift_bit_alu_pkg::*;

	logic        clk_i       = 1'b0;
	logic        rstn_i      = 1'b0;
	req_s        req_i       = '0;
	load_s       load_i      = '0;
	logic [2:0]  peek_idx_i  = 3'h0;
	logic        done_o;
	logic [31:0] result_o;
	flags_s      flags_o;
	logic        mem_wr_o;
	logic [7:0]  mem_data_o;
	logic [31:0] peek_data_o;
	int          failures    = 0;
	int          comparisons = 0;
	logic        exp_c       = 1'b0;
	logic [3:0]  exp_f       = 4'h0;

	always #2 clk_i = ~clk_i;

	logic_shift_bit_alu dut (
		.clk_i       (clk_i),
		.rstn_i      (rstn_i),
		.req_i       (req_i),
		.load_i      (load_i),
		.peek_idx_i  (peek_idx_i),
		.done_o      (done_o),
		.result_o    (result_o),
		.flags_o     (flags_o),
		.mem_wr_o    (mem_wr_o),
		.mem_data_o  (mem_data_o),
		.peek_data_o (peek_data_o)
	);

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic stop_test;
		if (failures == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic load_reg(input logic [2:0] idx, input logic [31:0] d);
		@(negedge clk_i);
		load_i = '{valid: 1'b1, idx: idx, data: d};
		@(negedge clk_i);
		load_i.valid = 1'b0;
	endtask : load_reg

	task automatic peek(input logic [2:0] idx, input logic [31:0] exp);
		@(negedge clk_i);
		peek_idx_i = idx;
		repeat (2) @(negedge clk_i);
		chk(peek_data_o, exp, "register");
	endtask : peek

	// The valid strobe drops one cycle after it rises, so each call is exactly one op.
	task automatic do_op(input op_e op, input size_e sz, input logic [3:0] d, input logic [3:0] s,
			input logic imm, input logic [31:0] iv, input logic mo, input logic [7:0] md);
		@(negedge clk_i);
		req_i = '{1'b1, op, sz, d, s, imm, iv, mo, md};
		@(negedge clk_i);
		req_i.valid = 1'b0;
		chk({31'h0, done_o}, 32'h1, "done");
	endtask : do_op

	task automatic chk_res(input logic [31:0] r, input logic v, input int m);
		exp_f = {r[m], r == 32'h0, v, exp_c};
		chk(result_o, r, "result");
		chk({28'h0, flags_o}, {28'h0, exp_f}, "flags");
	endtask : chk_res

	function automatic logic [33:0] ref_sh(input int o, input logic [31:0] a, input int m,
			input logic [31:0] mk, input logic cin);
		logic [31:0] r;
		logic        c;
		c = (o == 4 || o == 6 || o == 8 || o == 10) ? a[m] : a[0];
		case (o)
			4, 6:    r = a << 1;
			5:       r = (a >> 1) | (a & (32'h1 << m));
			7:       r = a >> 1;
			8:       r = (a << 1) | {31'h0, a[m]};
			9:       r = (a >> 1) | ({31'h0, a[0]} << m);
			10:      r = (a << 1) | {31'h0, cin};
			default: r = (a >> 1) | ({31'h0, cin} << m);
		endcase
		r = r & mk;
		return {(o == 4) && (a[m] ^ r[m]), c, r};
	endfunction : ref_sh

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_logic;
		load_reg(3'h0, 32'hf0f0_1234);
		load_reg(3'h1, 32'h0ff0_ff00);
		do_op(OP_AND, SZ_LONG, 4'h0, 4'h1, 1'b0, 32'h0, 1'b0, 8'h0);
		chk_res(32'h00f0_1200, 1'b0, 31);
		do_op(OP_OR, SZ_LONG, 4'h0, 4'h0, 1'b1, 32'h8000_0001, 1'b0, 8'h0);
		chk_res(32'h80f0_1201, 1'b0, 31);
		do_op(OP_XOR, SZ_WORD, 4'h8, 4'h9, 1'b0, 32'h0, 1'b0, 8'h0);
		chk_res(32'h0000_8f00, 1'b0, 15);
		do_op(OP_AND, SZ_BYTE, 4'h8, 4'h0, 1'b1, 32'h0000_ff0e, 1'b0, 8'h0);
		chk_res(32'h0, 1'b0, 7);
		peek(3'h0, 32'h8f00_1200);
		do_op(OP_OR, SZ_WORD, 4'h0, 4'h1, 1'b0, 32'h0, 1'b0, 8'h0);
		chk_res(32'h0000_ff00, 1'b0, 15);
		do_op(OP_XOR, SZ_BYTE, 4'h0, 4'h0, 1'b1, 32'h0000_013c, 1'b0, 8'h0);
		chk_res(32'h0000_00c3, 1'b0, 7);
		peek(3'h0, 32'h8f00_c300);
	endtask : t_logic

	task automatic t_not;
		load_reg(3'h3, 32'h1234_5678);
		do_op(OP_NOT, SZ_BYTE, 4'h3, 4'h0, 1'b0, 32'h0, 1'b0, 8'h0);
		chk_res(32'h0000_00a9, 1'b0, 7);
		peek(3'h3, 32'h1234_a978);
		do_op(OP_NOT, SZ_WORD, 4'hb, 4'h0, 1'b0, 32'h0, 1'b0, 8'h0);
		chk_res(32'h0000_edcb, 1'b0, 15);
		peek(3'h3, 32'hedcb_a978);
		do_op(OP_NOT, SZ_LONG, 4'h3, 4'h0, 1'b0, 32'h0, 1'b0, 8'h0);
		chk_res(32'h1234_5687, 1'b0, 31);
		peek(3'h3, 32'h1234_5687);
	endtask : t_not

	task automatic t_shift;
		int          o;
		int          m;
		logic [31:0] a;
		logic [31:0] mk;
		logic [33:0] e;
		for (int s = 0; s < 3; s++) begin
			m = (s == 0) ? 7 : (s == 1) ? 15 : 31;
			mk = (s == 0) ? 32'hff : (s == 1) ? 32'hffff : 32'hffff_ffff;
			load_reg(3'h2, 32'h8000_8081);
			a = 32'h8000_8081 & mk;
			for (o = 11; o > 3; o--) begin
				e = ref_sh(o, a, m, mk, exp_c);
				do_op(op_e'(o), size_e'(s), (s == 0) ? 4'ha : 4'h2, 4'h0, 1'b0, 32'h0, 1'b0, 8'h0);
				exp_c = e[32];
				chk_res(e[31:0], e[33], m);
				a = e[31:0];
			end
			peek(3'h2, (32'h8000_8081 & ~mk) | a);
		end
	endtask : t_shift

	task automatic t_bits;
		load_reg(3'h4, 32'h0000_00f0);
		load_reg(3'h5, 32'h0000_0005);
		do_op(OP_BIT_SET, SZ_BYTE, 4'hc, 4'h0, 1'b1, 32'h3, 1'b0, 8'h0);
		chk({31'h0, mem_wr_o}, 32'h0, "memory strobe");
		do_op(OP_BIT_CLEAR, SZ_BYTE, 4'hc, 4'hd, 1'b0, 32'h0, 1'b0, 8'h0);
		peek(3'h4, 32'h0000_00d8);
		do_op(OP_BIT_SET, SZ_WORD, 4'hc, 4'h0, 1'b1, 32'h0, 1'b0, 8'h0);
		peek(3'h4, 32'h0000_00d9);
		do_op(OP_BIT_CLEAR, SZ_BYTE, 4'h0, 4'hd, 1'b0, 32'h0, 1'b1, 8'hff);
		chk({31'h0, mem_wr_o}, 32'h1, "memory strobe");
		chk({24'h0, mem_data_o}, 32'h0000_00df, "memory byte");
		do_op(OP_BIT_SET, SZ_BYTE, 4'h0, 4'h0, 1'b1, 32'h7, 1'b1, 8'h00);
		chk({24'h0, mem_data_o}, 32'h0000_0080, "memory byte");
		chk({28'h0, flags_o}, {28'h0, exp_f}, "flags");
	endtask : t_bits

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		rstn_i = 1'b1;
		t_logic();
		t_not();
		t_shift();
		t_bits();
		stop_test();
	end

	initial begin
		#20000;
		failures++;
		$display("MISMATCH %0t watchdog expired", $time);
		stop_test();
	end

endmodule : tb
